// ### verilog/bsc_pkg.sv
// constants, states and carriers of the burner sequence controller
// assumes a 200 MHz mclk and temperatures in whole degrees celsius
package bsc_pkg;
   // ==========================================
   // clock and time base
   localparam int CLK_MHZ = 200;
   localparam int TICK_MS = 1000;
   localparam int TICK_CYCLES = TICK_MS * 1000 * CLK_MHZ;
   // sequence durations in seconds
   localparam logic [7:0] INIT_S = 8'h0F; // 15 s
   localparam logic [7:0] INIT_COLD_S = 8'h28; // 40 s
   localparam logic [7:0] PREIGN_S = 8'h01; // 1 s
   localparam logic [7:0] SAFETY_S = 8'h0A; // 10 s
   localparam logic [7:0] STAB_S = 8'h05; // 5 s
   localparam logic [7:0] PURGE1_S = 8'h05; // 5 s
   localparam logic [7:0] PURGE_S = 8'h73; // 115 s
   // ==========================================
   // temperatures, signed degrees
   localparam logic signed [7:0] T_LOWER = 8'sh48; // 72 C
   localparam logic signed [7:0] T_UPPER = 8'sh52; // 82 C
   localparam logic signed [7:0] T_COLD = 8'shEC; // -20 C
   localparam logic signed [7:0] T_STEP = 8'sh05; // per gradient step
   localparam logic [7:0] GRAD_LIM_RST = 8'h02; // C per second
   // ==========================================
   // interlock and flash code
   localparam logic [3:0] MAX_LOCKS = 4'h8;
   localparam logic [7:0] FLASH_PAUSE = 8'h03;
   localparam logic [2:0] E_NONE = 3'h0;
   localparam logic [2:0] E_NOFLAME = 3'h1;
   localparam logic [2:0] E_FLINIT = 3'h2;
   localparam logic [2:0] E_FAULT = 3'h3;
   localparam logic [2:0] E_FLPURGE = 3'h4;
   localparam logic [2:0] E_FLOUT = 3'h5;
   // ==========================================
   // register map, byte addresses
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_STAT = 8'h04;
   localparam logic [7:0] A_ERR = 8'h08;
   localparam int B_SWON = 0;
   localparam int B_GLIM = 8;
   // ==========================================
   // types
   typedef enum logic [10:0] {
      S_OFF = 11'h001, S_INIT = 11'h002, S_PREIGN = 11'h004,
      S_SAFE = 11'h008, S_STAB = 11'h010, S_HEAT = 11'h020,
      S_PURGE1 = 11'h040, S_PURGE2 = 11'h080, S_BREAK = 11'h100,
      S_LOCK = 11'h200, S_HLOCK = 11'h400
   } bsc_state_t;
   typedef enum logic [1:0] {
      PR_TEMP = 2'h0, PR_OFF = 2'h1, PR_FAULT = 2'h2, PR_HLOCK = 2'h3
   } bsc_why_t;
   typedef struct packed {
      logic indicator;
      logic fan;
      logic high_pressure_gas_valve;
      logic low_pressure_gas_valve;
      logic ignition_flame_module;
      logic pump;
      logic flame_mon;
   } bsc_act_t;
endpackage

// ### verilog/bsc_top.sv
// burner sequence controller: start, heat, purge, break, interlocks
// assumes inputs synchronous to mclk and a classic wishbone master
//
// What this block does
// - start burner below 72 C, stop at 82 C, one regulation mode
// - fast temperature rise lowers both thresholds, faster rise lowers further
// - rise back within limit restores 72 C and 82 C at once
// - on request: indicator on, start only if below upper threshold
// - initial cycle 15 s, or 40 s below -20 C
// - initial cycle runs the fan and watches the flame input
// - open high pressure valve together with the igniter at pre-ignition
// - pre-ignition: igniter on, low pressure valve 1 s later
// - low pressure valve opening starts 10 s safety time
// - flame leads to stabilisation, heating only if flame still there
// - off request, overtemperature or fault during start leads to purge
// - heating keeps indicator, pump, fan, both valves, monitoring on
// - upper threshold in heating closes valves, fan and pump keep running
// - after 5 s of purge, second phase watches the flame input
// - after 115 s temperature purge, fan stops, controlled break follows
// - flame in second purge phase stops fan, raises error till 115 s
// - break restarts with the normal start below lower threshold
// - off request: indicator off, valves closed, purge with fan and pump
// - switch-off purge end turns fan, monitoring and pump off
// - malfunction: fault shutdown with purge, then malfunction interlock
// - malfunction interlock flashes error code on the indicator
// - successive malfunction interlocks are counted and escalate
// - no flame within 10 s of low pressure valve is a malfunction
// - eighth malfunction gives heater interlock; no start or purge then
// - flame in second purge phase leads to heater interlock
//
// Decided for this implementation: the Wishbone register port and the register addresses.
module bsc_top
   import bsc_pkg::*;
#(
   parameter int TICK_CYC = TICK_CYCLES // shorten in simulation
)(
   input wire logic mclk, // 200 MHz clock
   input wire logic reset, // synchronous, active high
   input wire logic [7:0] wb_adr_i, // byte address
   input wire logic [31:0] wb_dat_i, // write data
   input wire logic [3:0] wb_sel_i, // byte enables
   input wire logic wb_we_i, // write strobe
   input wire logic wb_cyc_i, // cycle
   input wire logic wb_stb_i, // strobe
   output logic [31:0] wb_dat_o, // read data
   output logic wb_ack_o, // acknowledge
   input wire logic on_request, // heater switch
   input wire logic signed [7:0] coolant_temp, // degrees C
   input wire logic flame_detect, // flame guard
   input wire logic fault_in, // component malfunction
   output bsc_act_t act_o, // actuators
   output logic heater_locked_o // heater interlock
);

   // ==========================================
   // declarations
   bsc_state_t state_q, state_d;
   bsc_why_t why_q, why_d;
   bsc_act_t act_d;
   logic [27:0] presc_q;
   logic tick_q;
   logic [7:0] sec_q;
   logic signed [7:0] prev_q, thr_up_q, thr_lo_q;
   logic signed [8:0] rise;
   logic [1:0] step_d, step_q;
   logic [3:0] lock_cnt_q;
   logic [2:0] err_q, err_d;
   logic err_ev;
   logic [7:0] flash_q, flash_len;
   logic swon_q;
   logic [7:0] glim_q;
   logic on_req, hot, wb_req;
   logic [7:0] init_len;

   // threshold lowered by a number of gradient steps
   function automatic logic signed [7:0] lowered(
      input logic signed [7:0] base, input logic [1:0] st);
      logic signed [7:0] r;
      r = base;
      case (st)
         2'h1: r = base - T_STEP;
         2'h2: r = base - T_STEP - T_STEP;
         default: r = base;
      endcase
      return r;
   endfunction

   // ==========================================
   // one second time base
   // prescaler restarts on every state change so each phase is exact
   always_ff @(posedge mclk)
   begin
      if (reset || state_d != state_q)
      begin
         presc_q <= 28'h0000000;
         tick_q <= 1'b0;
      end
      else if (presc_q == 28'(TICK_CYC - 1))
      begin
         presc_q <= 28'h0000000;
         tick_q <= 1'b1;
      end
      else
      begin
         presc_q <= presc_q + 28'h0000001;
         tick_q <= 1'b0;
      end
   end

   // seconds spent in the current state
   always_ff @(posedge mclk)
   begin
      if (reset || state_d != state_q)
         sec_q <= 8'h00;
      else if (tick_q && sec_q != 8'hFF)
         sec_q <= sec_q + 8'h01;
   end

   // ==========================================
   // gradient evaluation, sampled once a second
   assign rise = 9'(coolant_temp) - 9'(prev_q);

   always_comb
   begin
      if (rise > $signed({1'b0, glim_q}) + $signed({1'b0, glim_q}))
         step_d = 2'h2;
      else if (rise > $signed({1'b0, glim_q}))
         step_d = 2'h1;
      else
         step_d = 2'h0;
   end

   // thresholds move only on ticks; restore is immediate on that tick
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         prev_q <= 8'sh00;
         step_q <= 2'h0;
         thr_up_q <= T_UPPER;
         thr_lo_q <= T_LOWER;
      end
      else if (tick_q)
      begin
         prev_q <= coolant_temp;
         step_q <= step_d;
         thr_up_q <= lowered(T_UPPER, step_d);
         thr_lo_q <= lowered(T_LOWER, step_d);
      end
   end

   // ==========================================
   // sequence control
   assign on_req = on_request | swon_q;
   assign hot = coolant_temp >= thr_up_q;
   assign init_len = (coolant_temp < T_COLD) ? INIT_COLD_S : INIT_S;

   always_comb
   begin
      state_d = state_q;
      why_d = why_q;
      err_ev = 1'b0;
      err_d = E_NONE;
      case (state_q)
         S_OFF:
            if (on_req)
               state_d = hot ? S_BREAK : S_INIT;
         S_INIT, S_PREIGN, S_SAFE, S_STAB:
         begin
            // abort of the start takes priority over progress
            if (!on_req)
            begin
               state_d = S_PURGE1;
               why_d = PR_OFF;
            end
            else if (fault_in || (state_q == S_INIT && flame_detect))
            begin
               state_d = S_PURGE1;
               why_d = PR_FAULT;
               err_ev = 1'b1;
               err_d = fault_in ? E_FAULT : E_FLINIT;
            end
            else if (hot)
            begin
               state_d = S_PURGE1;
               why_d = PR_TEMP;
            end
            else if (state_q == S_INIT && sec_q >= init_len)
               state_d = S_PREIGN;
            else if (state_q == S_PREIGN && sec_q >= PREIGN_S)
               state_d = S_SAFE;
            else if (state_q == S_SAFE && flame_detect)
               state_d = S_STAB;
            else if (state_q == S_SAFE && sec_q >= SAFETY_S)
            begin
               state_d = S_PURGE1;
               why_d = PR_FAULT;
               err_ev = 1'b1;
               err_d = E_NOFLAME;
            end
            else if (state_q == S_STAB && sec_q >= STAB_S)
            begin
               if (flame_detect)
                  state_d = S_HEAT;
               else
               begin
                  state_d = S_PURGE1;
                  why_d = PR_FAULT;
                  err_ev = 1'b1;
                  err_d = E_FLOUT;
               end
            end
         end
         S_HEAT:
         begin
            if (!on_req)
            begin
               state_d = S_PURGE1;
               why_d = PR_OFF;
            end
            else if (fault_in || !flame_detect)
            begin
               state_d = S_PURGE1;
               why_d = PR_FAULT;
               err_ev = 1'b1;
               err_d = fault_in ? E_FAULT : E_FLOUT;
            end
            else if (hot)
            begin
               state_d = S_PURGE1;
               why_d = PR_TEMP;
            end
         end
         S_PURGE1:
         begin
            if (!on_req && why_q == PR_TEMP)
               why_d = PR_OFF;
            if (sec_q >= PURGE1_S)
               state_d = S_PURGE2;
         end
         S_PURGE2:
         begin
            if (flame_detect && why_q != PR_HLOCK)
            begin
               why_d = PR_HLOCK;
               err_ev = 1'b1;
               err_d = E_FLPURGE;
            end
            else if (!on_req && why_q == PR_TEMP)
               why_d = PR_OFF;
            // second phase lasts the rest of the full purge time
            if (sec_q >= PURGE_S - PURGE1_S)
            begin
               case (why_d)
                  PR_HLOCK: state_d = S_HLOCK;
                  PR_FAULT: state_d = (lock_cnt_q == MAX_LOCKS - 4'h1) ?
                                      S_HLOCK : S_LOCK;
                  PR_OFF: state_d = S_OFF;
                  default: state_d = S_BREAK;
               endcase
            end
         end
         S_BREAK:
         begin
            if (!on_req)
               state_d = S_OFF;
            else if (fault_in)
            begin
               // escalation applies here too, else the count could wrap past the limit
               state_d = (lock_cnt_q == MAX_LOCKS - 4'h1) ?
                         S_HLOCK : S_LOCK;
               err_ev = 1'b1;
               err_d = E_FAULT;
            end
            else if (coolant_temp < thr_lo_q)
               state_d = S_INIT;
         end
         S_LOCK:
            if (!on_req)
               state_d = S_OFF; // switching off releases
         S_HLOCK:
            state_d = S_HLOCK;
         default:
            state_d = S_OFF;
      endcase
   end

   // state and purge cause
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         state_q <= S_OFF;
         why_q <= PR_TEMP;
      end
      else
      begin
         state_q <= state_d;
         why_q <= why_d;
      end
   end

   // successive malfunction interlocks, cleared by a good heating phase
   always_ff @(posedge mclk)
   begin
      if (reset || state_q == S_HEAT)
         lock_cnt_q <= 4'h0;
      else if (state_d == S_LOCK && state_q != S_LOCK)
         lock_cnt_q <= lock_cnt_q + 4'h1;
   end

   // ==========================================
   // flash code: code pulses of one second, then a pause
   assign flash_len = {4'h0, err_q, 1'b0} + FLASH_PAUSE;

   always_ff @(posedge mclk)
   begin
      if (reset || !(state_q == S_LOCK || state_q == S_HLOCK))
         flash_q <= 8'h00;
      else if (tick_q)
         flash_q <= (flash_q >= flash_len - 8'h01) ? 8'h00 : flash_q + 8'h01;
   end

   // ==========================================
   // actuator decode; registered so every output is a flop
   always_comb
   begin
      act_d = '0;
      case (state_q)
         S_INIT:
            act_d = '{indicator: 1'b1, fan: 1'b1, pump: 1'b1,
                      flame_mon: 1'b1, default: 1'b0};
         S_PREIGN, S_SAFE:
            act_d = '{indicator: 1'b1, fan: 1'b1, pump: 1'b1, flame_mon: 1'b1,
                      high_pressure_gas_valve: 1'b1,
                      ignition_flame_module: 1'b1,
                      low_pressure_gas_valve: state_q == S_SAFE};
         S_STAB, S_HEAT:
            act_d = '{indicator: 1'b1, fan: 1'b1, pump: 1'b1, flame_mon: 1'b1,
                      high_pressure_gas_valve: 1'b1,
                      low_pressure_gas_valve: 1'b1,
                      ignition_flame_module: 1'b0};
         S_PURGE1, S_PURGE2:
            act_d = '{indicator: why_q != PR_OFF, fan: why_q != PR_HLOCK,
                      pump: 1'b1, flame_mon: 1'b1,
                      default: 1'b0};
         S_BREAK:
            act_d = '{indicator: 1'b1, pump: 1'b1, flame_mon: 1'b1,
                      default: 1'b0};
         S_LOCK, S_HLOCK:
            act_d = '{indicator: flash_q < {4'h0, err_q, 1'b0} && !flash_q[0],
                      default: 1'b0};
         default:
            act_d = '0;
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         act_o <= '0;
         heater_locked_o <= 1'b0;
      end
      else
      begin
         act_o <= act_d;
         heater_locked_o <= state_q == S_HLOCK;
      end
   end

   // ==========================================
   // wishbone slave: one wait state, ack for every address
   assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

   always_ff @(posedge mclk)
   begin
      if (reset)
         wb_ack_o <= 1'b0;
      else
         wb_ack_o <= wb_req;
   end

   // control register
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         swon_q <= 1'b0;
         glim_q <= GRAD_LIM_RST;
      end
      else if (wb_req && wb_we_i && wb_adr_i == A_CTRL)
      begin
         if (wb_sel_i[0])
            swon_q <= wb_dat_i[B_SWON];
         if (wb_sel_i[1])
            glim_q <= wb_dat_i[B_GLIM +: 8];
      end
   end

   // last error code; a new error wins over a software clear
   always_ff @(posedge mclk)
   begin
      if (reset)
         err_q <= E_NONE;
      else if (err_ev)
         err_q <= err_d;
      else if (wb_req && wb_we_i && wb_adr_i == A_ERR && wb_sel_i[0])
         err_q <= E_NONE;
   end

   // read data, unmapped addresses read zero
   always_ff @(posedge mclk)
   begin
      if (reset)
         wb_dat_o <= 32'h00000000;
      else if (wb_req && !wb_we_i)
         case (wb_adr_i)
            A_CTRL: wb_dat_o <= {16'h0000, glim_q, 7'h00, swon_q};
            A_STAT: wb_dat_o <= {12'h000, step_q, 2'h0, lock_cnt_q,
                                 1'b0, state_q};
            A_ERR: wb_dat_o <= {8'h00, thr_lo_q, thr_up_q, 5'h00, err_q};
            default: wb_dat_o <= 32'h00000000;
         endcase
   end

   // ==========================================
   // assertions
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   a_start_gate: assert property (state_q == S_OFF && on_req && !hot
      |=> state_q == S_INIT)
      else $error("start not taken below upper threshold");
   a_valve_order: assert property ($rose(act_o.low_pressure_gas_valve)
      |-> act_o.ignition_flame_module && act_o.high_pressure_gas_valve
          && $past(act_o.ignition_flame_module))
      else $error("low pressure valve opened without igniter");
   a_no_flame: assert property (state_q == S_SAFE && on_req && !fault_in
      && !hot && !flame_detect && sec_q >= SAFETY_S
      |=> state_q == S_PURGE1 && err_q == E_NOFLAME)
      else $error("missing flame not treated as malfunction");
   a_heat_outputs: assert property (state_q == S_HEAT
      |=> act_o.fan && act_o.pump && act_o.indicator && act_o.flame_mon
          && act_o.high_pressure_gas_valve
          && act_o.low_pressure_gas_valve)
      else $error("heating outputs incomplete");
   a_purge_outputs: assert property (state_q == S_PURGE1
      |=> !act_o.low_pressure_gas_valve && !act_o.high_pressure_gas_valve
          && act_o.fan && act_o.pump)
      else $error("purge outputs wrong");
   a_break_outputs: assert property (state_q == S_BREAK
      |=> !act_o.fan && act_o.pump && act_o.flame_mon)
      else $error("break outputs wrong");
   a_hlock_stays: assert property (state_q == S_HLOCK
      |=> state_q == S_HLOCK ##1 heater_locked_o)
      else $error("heater interlock left");
   a_lock_count: assert property (state_q == S_PURGE2 && state_d == S_LOCK
      |-> lock_cnt_q < MAX_LOCKS - 4'h1)
      else $error("interlock count not escalated");
   a_thr_restore: assert property (tick_q && step_d == 2'h0
      |=> thr_up_q == T_UPPER && thr_lo_q == T_LOWER)
      else $error("thresholds not restored");
   a_flame_purge: assert property (state_q == S_PURGE2 && flame_detect
      |=> why_q == PR_HLOCK ##1 !act_o.fan)
      else $error("flame in purge not handled");
   a_wb_ack: assert property (wb_req |=> wb_ack_o ##1 !wb_ack_o)
      else $error("wishbone ack not single cycle");

   c_heat: cover property (state_q == S_STAB ##1 state_q == S_HEAT);
   c_break: cover property (state_q == S_PURGE2 ##1 state_q == S_BREAK);
   c_lock: cover property (state_q == S_PURGE2 ##1 state_q == S_LOCK);
   c_hlock: cover property (state_q == S_PURGE2 ##1 state_q == S_HLOCK);

endmodule

// ### bench/bsc_burner_model.sv
// burner side model: gas valve, igniter and flame guard behaviour
// assumes act_o from the controller and a bench switch for ignition success
module bsc_burner_model
   import bsc_pkg::*;
(
   input wire logic mclk, // controller clock
   input wire bsc_act_t act, // actuator levels
   input wire logic ignite_ok, // bench: mixture lights
   input wire logic stuck_flame, // bench: defective guard reports flame
   output logic flame_detect // flame guard level
);
   // ==========================================
   // flame: lit by the spark while gas flows, then kept while gas flows
   // no gas means no flame at once, so a closed valve shows flame only while stuck_flame is set
   initial flame_detect = 1'b0;
   always @(posedge mclk)
   begin
      flame_detect <= stuck_flame | (act.low_pressure_gas_valve &
         (flame_detect | (ignite_ok & act.ignition_flame_module)));
   end
endmodule

// ### bench/tb_top.sv
// sequence bench for the burner controller: bus tasks and timed walks
// assumes bsc_top with a short tick and the burner model on its actuators
module tb_top
   import bsc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TK = 20; // cycles per tick, seconds become 20 cycles
   logic mclk, reset, wb_we, wb_cyc, wb_stb, ign_ok, flame, wb_ack;
   logic onr, stuck, hlock;
   logic [7:0] wb_adr;
   logic [31:0] wb_wdat, wb_rdat, q;
   logic signed [7:0] temp;
   logic [6:0] a;
   bsc_act_t act;
   int fails = 0, n_tests = 0, n;
   assign a = act;
   bsc_top #(.TICK_CYC(TK)) bsc_top_i (.mclk(mclk), .reset(reset), .wb_adr_i(wb_adr),
      .wb_dat_i(wb_wdat), .wb_sel_i(4'hF), .wb_we_i(wb_we), .wb_cyc_i(wb_cyc),
      .wb_stb_i(wb_stb), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .on_request(onr),
      .coolant_temp(temp), .flame_detect(flame), .fault_in(1'b0), .act_o(act),
      .heater_locked_o(hlock));
   bsc_burner_model bsc_burner_model_i (.mclk(mclk), .act(act), .ignite_ok(ign_ok),
      .stuck_flame(stuck), .flame_detect(flame));
   // ==========================================
   // clock and watchdog; the walk needs about 11k cycles
   initial
   begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   initial
   begin
      repeat (60000) @(posedge mclk);
      fails++;
      end_of_test();
   end
   // ==========================================
   // helpers
   task end_of_test();
      $display("tests %0d fails %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e)
      begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task rng(input int v, input int lo, input int hi);
      chk(v, (v >= lo && v <= hi) ? v : lo);
   endtask
   // one classic cycle; ack and read data are taken at the rising edge itself
   task wb(input logic [7:0] ad, input logic w, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge mclk);
      wb_adr <= ad;
      wb_we <= w;
      wb_wdat <= d;
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      do
      begin
         @(posedge mclk);
         k++;
      end while (wb_ack !== 1'b1 && k < 100);
      q = wb_rdat;
      if (k >= 100)
         fails++;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we <= 1'b0;
   endtask
   // waits for masked actuators to match, n counts the cycles spent
   task wa(input logic [6:0] m, input logic [6:0] e, input int lim);
      n = 0;
      while ((a & m) !== e && n < lim)
      begin
         @(negedge mclk);
         n++;
      end
      if (n >= lim)
         chk(a & m, e);
   endtask
   // ==========================================
   // main walk
   initial
   begin
      reset = 1'b1; wb_we = 1'b0; wb_cyc = 1'b0; wb_stb = 1'b0;
      wb_adr = 8'h00; wb_wdat = 32'h0; ign_ok = 1'b1; temp = 8'sh14;
      onr = 1'b0; stuck = 1'b0;
      repeat (20) @(posedge mclk);
      reset <= 1'b0;
      wb(A_STAT, 1'b0, 32'h0); chk(q, 32'h00000001);
      wb(A_CTRL, 1'b0, 32'h0); chk(q, 32'h00000200);
      wb(A_ERR, 1'b0, 32'h0); chk(q, 32'h00485200);
      wb(8'h0C, 1'b0, 32'h0); chk(q, 32'h00000000);
      // normal start to heating
      wb(A_CTRL, 1'b1, 32'h00000201);
      wa(7'h40, 7'h40, 10); chk(a & 7'h63, 7'h63);
      wa(7'h04, 7'h04, 400); rng(n, 298, 308);
      wa(7'h08, 7'h08, 40); rng(n, 18, 26); chk(a[4], 1'b1);
      wa(7'h7B, 7'h7B, 200); chk(a & 7'h7B, 7'h7B);
      repeat (110) @(posedge mclk);
      wb(A_STAT, 1'b0, 32'h0); chk(q[10:0], 11'h020);
      wb(A_ERR, 1'b0, 32'h0); chk(q[23:8], 16'h4852);
      // fast rise lowers both thresholds by two steps, then restores
      @(posedge mclk) temp <= 8'sh46;
      for (int i = 0; i < 20 && q[15:8] === 8'h52; i++) wb(A_ERR, 1'b0, 32'h0);
      chk(q[23:8], 16'h3E48);
      for (int i = 0; i < 20 && q[15:8] !== 8'h52; i++) wb(A_ERR, 1'b0, 32'h0);
      chk(q[23:8], 16'h4852);
      // overtemperature purge, then controlled break
      @(posedge mclk) temp <= 8'sh55;
      wa(7'h7A, 7'h62, 30);
      wa(7'h7B, 7'h43, 2400); rng(n, 2290, 2312);
      // restart from break, switched off in the start
      @(posedge mclk) temp <= 8'sh14;
      wa(7'h20, 7'h20, 40);
      wa(7'h04, 7'h04, 400); rng(n, 298, 308);
      wb(A_CTRL, 1'b1, 32'h00000200);
      wa(7'h7A, 7'h22, 10);
      wa(7'h7F, 7'h00, 2400); rng(n, 2290, 2312);
      // cold start that never lights: malfunction and flash code
      @(posedge mclk) ign_ok <= 1'b0;
      temp <= 8'shE2;
      wb(A_CTRL, 1'b1, 32'h00000201);
      wa(7'h40, 7'h40, 10);
      wa(7'h04, 7'h04, 900); rng(n, 798, 808);
      wa(7'h08, 7'h08, 40);
      wa(7'h08, 7'h00, 300); rng(n, 198, 206);
      wa(7'h20, 7'h00, 2400);
      wb(A_STAT, 1'b0, 32'h0); chk(q, 32'h00001200);
      wb(A_ERR, 1'b0, 32'h0); chk(q, 32'h00485201);
      wa(7'h40, 7'h00, 40);
      wa(7'h40, 7'h40, 200);
      wa(7'h40, 7'h00, 40); rng(n, 18, 24);
      // switching off releases; a guard stuck on flame ends in heater interlock
      wb(A_CTRL, 1'b1, 32'h00000200);
      wa(7'h7F, 7'h00, 10); chk(a, 7'h00);
      @(posedge mclk);
      stuck <= 1'b1;
      onr <= 1'b1;
      wa(7'h20, 7'h20, 10);
      wa(7'h20, 7'h00, 200); rng(n, 95, 115);
      wb(A_ERR, 1'b0, 32'h0); chk(q[2:0], E_FLPURGE);
      chk(a & 7'h43, 7'h43);
      for (n = 0; n < 2400 && hlock !== 1'b1; n++) @(negedge mclk);
      rng(n, 2170, 2215);
      @(posedge mclk) onr <= 1'b0;
      repeat (5) @(posedge mclk);
      onr <= 1'b1;
      repeat (50) @(negedge mclk);
      wb(A_STAT, 1'b0, 32'h0); chk(q[10:0], 11'h400);
      chk(hlock, 1'b1);
      chk(a & 7'h3F, 7'h00);
      end_of_test();
   end
endmodule
